// *** hw/wss_winding_select.sv ***
// module: winding changeover sequencer with parameter registers
//
// Notes on behaviour
// - a request bit that differs from the winding status starts a changeover, unless the method is 0.
// - servo off and base block first, contactor output switches 10 ms later.
// - load the requested gain bank and configure for the new winding.
// - hold base block until contactor feedback shows the requested winding.
// - status flag updates only when done: 0 high-speed, 1 low-speed.
// - speed-match flag goes 1 once the commanded speed is reached.
// - motor-type digit decodes 0..5 to the six motor kinds.
// - winding-method digit: 0 none, 1 mechanical, 2 electronic; reset 0.
// - config accepts 0x0000..0x0025 with both digits legal, reset 0x0000, applies after restart.
// - per-winding flux level 30..100 percent, default 100, immediate.
// - per-winding base speed ratio 100..500 percent, default 100, immediate.
// - the request travels in bit 31 of the servo command word.
`timescale 1ns/1ps
module wss_winding_select import wss_pkg::*; #(
	parameter int unsigned SWITCH_DELAY = SWITCH_DELAY_CYC
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [DATA_W-1:0] regRdData,
	input wire logic [31:0] servoCmdWord,
	input wire logic servoCmdValid,
	input wire logic speedReached,
	input wire logic contactorFbLowPin,
	output logic servoOn,
	output logic baseBlock,
	output logic contactorDriveLow,
	output logic [GSEL_W-1:0] gainBank,
	output logic gainLoad,
	output logic controlLow,
	output logic windingStatus,
	output logic speedMatch,
	output logic [15:0] fluxLevel,
	output logic [15:0] baseSpeedRatio,
	output wss_motor_t motorType,
	output wss_method_t windingMethod
);

	// ----------------------------------------
	// contactor feedback pin
	// ----------------------------------------
	logic fbLow;

	wss_pin_sync uFbSync (
		.clock(clock),
		.rst_n(rst_n),
		.pinIn(contactorFbLowPin),
		.level(fbLow)
	);

	// ----------------------------------------
	// parameter registers
	// ----------------------------------------
	logic [15:0] cfg_q, cfg_d, actCfg_q, actCfg_d;
	logic [15:0] hiFlux_q, hiFlux_d, hiBase_q, hiBase_d;
	logic [15:0] loFlux_q, loFlux_d, loBase_q, loBase_d;
	logic [15:0] rd_q, rd_d, statusWord;
	wss_state_t state_q, state_d;

	function automatic logic inRange(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		inRange = (v >= lo) && (v <= hi);
	endfunction

	always_comb begin
		cfg_d = cfg_q;
		actCfg_d = actCfg_q;
		hiFlux_d = hiFlux_q;
		hiBase_d = hiBase_q;
		loFlux_d = loFlux_q;
		loBase_d = loBase_q;
		rd_d = 16'h0000;
		// out-of-range writes are dropped so the stored value stays legal
		if (regWrite) begin
			unique case (regAddr)
				OFS_APP_CFG: begin
					if (regWrData <= APP_CFG_MAX && regWrData[3:0] <= MOTOR_DIGIT_MAX
						&& regWrData[7:4] <= METHOD_DIGIT_MAX) begin
						cfg_d = regWrData;
					end
				end
				OFS_HI_FLUX: begin
					if (inRange(regWrData, FLUX_MIN, FLUX_MAX)) begin
						hiFlux_d = regWrData;
					end
				end
				OFS_HI_BASE: begin
					if (inRange(regWrData, BASE_MIN, BASE_MAX)) begin
						hiBase_d = regWrData;
					end
				end
				OFS_LO_FLUX: begin
					if (inRange(regWrData, FLUX_MIN, FLUX_MAX)) begin
						loFlux_d = regWrData;
					end
				end
				OFS_LO_BASE: begin
					if (inRange(regWrData, BASE_MIN, BASE_MAX)) begin
						loBase_d = regWrData;
					end
				end
				OFS_CTRL: begin
					// restart: the stored config becomes the working config
					if (regWrData[CTRL_RESTART_BIT]) begin
						actCfg_d = cfg_q;
					end
				end
				default: begin
				end
			endcase
		end
		if (regRead) begin
			unique case (regAddr)
				OFS_APP_CFG: rd_d = cfg_q;
				OFS_HI_FLUX: rd_d = hiFlux_q;
				OFS_HI_BASE: rd_d = hiBase_q;
				OFS_LO_FLUX: rd_d = loFlux_q;
				OFS_LO_BASE: rd_d = loBase_q;
				OFS_STATUS: rd_d = statusWord;
				default: rd_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= APP_CFG_RST;
			actCfg_q <= APP_CFG_RST;
			hiFlux_q <= FLUX_RST;
			hiBase_q <= BASE_RST;
			loFlux_q <= FLUX_RST;
			loBase_q <= BASE_RST;
			rd_q <= 16'h0000;
		end else begin
			cfg_q <= cfg_d;
			actCfg_q <= actCfg_d;
			hiFlux_q <= hiFlux_d;
			hiBase_q <= hiBase_d;
			loFlux_q <= loFlux_d;
			loBase_q <= loBase_d;
			rd_q <= rd_d;
		end
	end

	assign regRdData = rd_q;
	assign motorType = wss_motor_t'(actCfg_q[2:0]);
	assign windingMethod = wss_method_t'(actCfg_q[5:4]);

	// ----------------------------------------
	// changeover sequencer
	// ----------------------------------------
	logic reqLow_q, reqLow_d, tgtLow_q, tgtLow_d;
	logic [GSEL_W-1:0] gainReq_q, gainReq_d, gainTgt_q, gainTgt_d;
	logic [GSEL_W-1:0] gainBank_q, gainBank_d;
	logic [31:0] cnt_q, cnt_d;
	logic servoOn_q, servoOn_d, bb_q, bb_d, drvLow_q, drvLow_d;
	logic ctlLow_q, ctlLow_d, status_q, status_d, match_q, match_d;
	logic load_q, load_d;
	logic [15:0] flux_q, flux_d, base_q, base_d;

	always_comb begin
		state_d = state_q;
		reqLow_d = reqLow_q;
		gainReq_d = gainReq_q;
		tgtLow_d = tgtLow_q;
		gainTgt_d = gainTgt_q;
		gainBank_d = gainBank_q;
		cnt_d = cnt_q;
		drvLow_d = drvLow_q;
		ctlLow_d = ctlLow_q;
		status_d = status_q;
		load_d = 1'b0;
		if (servoCmdValid) begin
			reqLow_d = servoCmdWord[REQ_BIT];
			gainReq_d = servoCmdWord[GSEL_LSB +: GSEL_W];
		end
		unique case (state_q)
			ST_RUN: begin
				// a request that differs from the present winding starts a changeover, unless the method is none
				if (windingMethod != WM_NONE && reqLow_q != status_q) begin
					tgtLow_d = reqLow_q;
					gainTgt_d = gainReq_q;
					cnt_d = 32'h0000_0000;
					state_d = ST_DELAY;
				end
			end
			ST_DELAY: begin
				cnt_d = cnt_q + 32'h0000_0001;
				if (cnt_q == 32'(SWITCH_DELAY - 1)) begin
					drvLow_d = tgtLow_q;
					state_d = ST_LOAD;
				end
			end
			ST_LOAD: begin
				gainBank_d = gainTgt_q;
				ctlLow_d = tgtLow_q;
				load_d = 1'b1;
				state_d = ST_VERIFY;
			end
			ST_VERIFY: begin
				// a stuck contactor leaves the drive in base block indefinitely
				if (fbLow == tgtLow_q) begin
					state_d = ST_DONE;
				end
			end
			ST_DONE: begin
				status_d = tgtLow_q;
				state_d = ST_RUN;
			end
			default: begin
				state_d = ST_RUN;
			end
		endcase
		servoOn_d = (state_d == ST_RUN);
		bb_d = (state_d != ST_RUN);
		// next state, not present state: match must drop in the same cycle as servo off
		match_d = speedReached && servoOn_q && (state_d == ST_RUN);
		// parameters of the winding in control apply at once
		flux_d = ctlLow_q ? loFlux_q : hiFlux_q;
		base_d = ctlLow_q ? loBase_q : hiBase_q;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_RUN;
			reqLow_q <= 1'b0;
			gainReq_q <= '0;
			tgtLow_q <= 1'b0;
			gainTgt_q <= '0;
			gainBank_q <= '0;
			cnt_q <= 32'h0000_0000;
			servoOn_q <= 1'b1;
			bb_q <= 1'b0;
			drvLow_q <= 1'b0;
			ctlLow_q <= 1'b0;
			status_q <= 1'b0;
			match_q <= 1'b0;
			load_q <= 1'b0;
			flux_q <= FLUX_RST;
			base_q <= BASE_RST;
		end else begin
			state_q <= state_d;
			reqLow_q <= reqLow_d;
			gainReq_q <= gainReq_d;
			tgtLow_q <= tgtLow_d;
			gainTgt_q <= gainTgt_d;
			gainBank_q <= gainBank_d;
			cnt_q <= cnt_d;
			servoOn_q <= servoOn_d;
			bb_q <= bb_d;
			drvLow_q <= drvLow_d;
			ctlLow_q <= ctlLow_d;
			status_q <= status_d;
			match_q <= match_d;
			load_q <= load_d;
			flux_q <= flux_d;
			base_q <= base_d;
		end
	end

	assign statusWord = {8'h00, state_q, fbLow, bb_q, servoOn_q, match_q, status_q};
	assign servoOn = servoOn_q;
	assign baseBlock = bb_q;
	assign contactorDriveLow = drvLow_q;
	assign gainBank = gainBank_q;
	assign gainLoad = load_q;
	assign controlLow = ctlLow_q;
	assign windingStatus = status_q;
	assign speedMatch = match_q;
	assign fluxLevel = flux_q;
	assign baseSpeedRatio = base_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	change_start_a: assert property (
		state_q == ST_RUN && windingMethod != WM_NONE && reqLow_q != status_q
		|=> state_q == ST_DELAY && bb_q && !servoOn_q)
		else $error("changeover did not start");
	contactor_delay_a: assert property (
		$changed(drvLow_q) |-> $past(state_q) == ST_DELAY
		&& $past(cnt_q) == 32'(SWITCH_DELAY - 1))
		else $error("contactor switched at wrong time");
	gain_load_a: assert property (
		load_q |-> gainBank_q == gainTgt_q && ctlLow_q == tgtLow_q && drvLow_q == tgtLow_q)
		else $error("gain bank not loaded");
	verify_hold_a: assert property (
		state_q == ST_VERIFY && fbLow != tgtLow_q |=> bb_q && !servoOn_q)
		else $error("base block lifted before verify");
	status_value_a: assert property (
		$changed(status_q) |-> $past(state_q) == ST_DONE && status_q == $past(tgtLow_q)
		&& servoOn_q && !bb_q)
		else $error("status updated out of place");
	speed_match_a: assert property (
		match_q |-> $past(speedReached) && $past(servoOn_q) && !bb_q)
		else $error("speed match without cause");
	busy_quiet_a: assert property (
		state_q != ST_RUN |-> !match_q)
		else $error("speed match during changeover");
	cfg_range_a: assert property (
		cfg_q <= APP_CFG_MAX && actCfg_q <= APP_CFG_MAX)
		else $error("config out of range");
	param_range_a: assert property (
		inRange(hiFlux_q, FLUX_MIN, FLUX_MAX) && inRange(loFlux_q, FLUX_MIN, FLUX_MAX)
		&& inRange(hiBase_q, BASE_MIN, BASE_MAX) && inRange(loBase_q, BASE_MIN, BASE_MAX))
		else $error("parameter out of range");
	restart_apply_a: assert property (
		regWrite && regAddr == OFS_CTRL && regWrData[CTRL_RESTART_BIT]
		|=> actCfg_q == $past(cfg_q))
		else $error("restart did not apply config");

	to_low_c: cover property (state_q == ST_DONE && tgtLow_q);
	to_high_c: cover property (state_q == ST_DONE && !tgtLow_q);
	verify_wait_c: cover property (state_q == ST_VERIFY ##1 state_q == ST_VERIFY);

endmodule

// *** hw/wss_pkg.sv ***
// package: constants, register map and types for the winding select sequencer
package wss_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned SWITCH_DELAY_MS = 10;
	// whole cycles of the contactor switch delay, rounded down
	localparam int unsigned SWITCH_DELAY_CYC = (CLK_HZ / 1000) * SWITCH_DELAY_MS;

	// ----------------------------------------
	// register map (word index on the plain port)
	// ----------------------------------------
	localparam int unsigned ADDR_W = 3;
	localparam int unsigned DATA_W = 16;
	localparam logic [2:0] OFS_APP_CFG = 3'h0;
	localparam logic [2:0] OFS_HI_FLUX = 3'h1;
	localparam logic [2:0] OFS_HI_BASE = 3'h2;
	localparam logic [2:0] OFS_LO_FLUX = 3'h3;
	localparam logic [2:0] OFS_LO_BASE = 3'h4;
	localparam logic [2:0] OFS_CTRL = 3'h5;
	localparam logic [2:0] OFS_STATUS = 3'h6;
	localparam int unsigned CTRL_RESTART_BIT = 0;

	// ----------------------------------------
	// reset values and legal ranges
	// ----------------------------------------
	localparam logic [15:0] APP_CFG_RST = 16'h0000;
	localparam logic [15:0] APP_CFG_MAX = 16'h0025;
	localparam logic [15:0] FLUX_RST = 16'h0064;
	localparam logic [15:0] FLUX_MIN = 16'h001e;
	localparam logic [15:0] FLUX_MAX = 16'h0064;
	localparam logic [15:0] BASE_RST = 16'h0064;
	localparam logic [15:0] BASE_MIN = 16'h0064;
	localparam logic [15:0] BASE_MAX = 16'h01f4;
	localparam logic [3:0] MOTOR_DIGIT_MAX = 4'h5;
	localparam logic [3:0] METHOD_DIGIT_MAX = 4'h2;

	// ----------------------------------------
	// servo command word fields
	// ----------------------------------------
	localparam int unsigned REQ_BIT = 31;
	localparam int unsigned GSEL_LSB = 0;
	localparam int unsigned GSEL_W = 2;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {
		MT_SURF_SERVO = 3'b000,
		MT_SURF_SPINDLE = 3'b001,
		MT_IND_SERVO = 3'b010,
		MT_IND_SPINDLE = 3'b011,
		MT_INT_SERVO = 3'b100,
		MT_INT_SPINDLE = 3'b101
	} wss_motor_t;

	typedef enum logic [1:0] {
		WM_NONE = 2'b00,
		WM_MECH = 2'b01,
		WM_ELEC = 2'b10
	} wss_method_t;

	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_DELAY = 3'b001,
		ST_LOAD = 3'b010,
		ST_VERIFY = 3'b011,
		ST_DONE = 3'b100
	} wss_state_t;

endpackage

// *** hw/wss_pin_sync.sv ***
// module: three-stage synchroniser for one external pin level
`timescale 1ns/1ps
module wss_pin_sync (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic pinIn,
	output logic level
);

	// ----------------------------------------
	// stages
	// ----------------------------------------
	logic s1_q, s2_q, s3_q, level_q;
	logic level_d;

	// the level moves only once stages two and three agree
	always_comb begin
		level_d = level_q;
		if (s2_q == s3_q) begin
			level_d = s3_q;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			level_q <= 1'b0;
		end else begin
			s1_q <= pinIn;
			s2_q <= s1_q;
			s3_q <= s2_q;
			level_q <= level_d;
		end
	end

	assign level = level_q;

endmodule

// *** testbench/wss_host_model.sv ***
// partner model: contactor and speed loop on the far side of the sequencer
`timescale 1ns/1ps
module wss_host_model (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic contactorDriveLow,
	input wire logic servoOn,
	input wire logic [7:0] fbDelay,
	output logic contactorFbLowPin,
	output logic speedReached
);
	// ----------------------------------------
	// contactor travel and motor speed
	// ----------------------------------------
	logic [7:0] travel_q;
	logic [2:0] spin_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			contactorFbLowPin <= 1'b0;
			travel_q <= 8'h00;
			spin_q <= 3'h0;
			speedReached <= 1'b0;
		end else begin
			// contact moves only after fbDelay cycles, so slow parts are covered
			if (contactorDriveLow == contactorFbLowPin) begin
				travel_q <= 8'h00;
			end else if (travel_q >= fbDelay) begin
				contactorFbLowPin <= contactorDriveLow;
				travel_q <= 8'h00;
			end else begin
				travel_q <= travel_q + 8'h01;
			end
			// step command at max rate: speed is reached a few cycles after servo on
			if (!servoOn) begin
				spin_q <= 3'h0;
				speedReached <= 1'b0;
			end else if (spin_q != 3'h4) begin
				spin_q <= spin_q + 3'h1;
			end else begin
				speedReached <= 1'b1;
			end
		end
	end
endmodule

// *** testbench/tb.sv ***
// testbench: self-checking bench for the winding select sequencer
`timescale 1ns/1ps
module tb import wss_pkg::*; ;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	// short switch delay keeps the run brief
	localparam int D = 8;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] regAddr = 3'h0;
	logic [15:0] regWrData = 16'h0000;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [31:0] servoCmdWord = 32'h0000_0000;
	logic servoCmdValid = 1'b0;
	logic [7:0] fbDelay = 8'h02;
	logic [15:0] regRdData, fluxLevel, baseSpeedRatio, rv, hiF, loF;
	logic speedReached, contactorFbLowPin, servoOn, baseBlock, contactorDriveLow;
	logic gainLoad, controlLow, windingStatus, speedMatch;
	logic [1:0] gainBank, g;
	wss_motor_t motorType;
	wss_method_t windingMethod;
	int n_mismatch = 0;
	int total_checks = 0;
	int i, c;

	always #5 clock = ~clock;

	wss_winding_select #(.SWITCH_DELAY(D)) wss_winding_select_inst (.clock(clock), .rst_n(rst_n),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .servoCmdWord(servoCmdWord), .servoCmdValid(servoCmdValid),
		.speedReached(speedReached), .contactorFbLowPin(contactorFbLowPin), .servoOn(servoOn),
		.baseBlock(baseBlock), .contactorDriveLow(contactorDriveLow), .gainBank(gainBank),
		.gainLoad(gainLoad), .controlLow(controlLow), .windingStatus(windingStatus),
		.speedMatch(speedMatch), .fluxLevel(fluxLevel), .baseSpeedRatio(baseSpeedRatio),
		.motorType(motorType), .windingMethod(windingMethod));

	wss_host_model wss_host_model_inst (.clock(clock), .rst_n(rst_n),
		.contactorDriveLow(contactorDriveLow), .servoOn(servoOn), .fbDelay(fbDelay),
		.contactorFbLowPin(contactorFbLowPin), .speedReached(speedReached));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		total_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic final_report();
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clock);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1;
		d = regRdData;
	endtask

	task automatic send(input logic req, input logic [1:0] gs);
		@(posedge clock);
		servoCmdWord <= {req, 29'h0, gs};
		servoCmdValid <= 1'b1;
		@(posedge clock);
		servoCmdValid <= 1'b0;
	endtask

	// bounded wait on one output; a run-out counts and ends the run
	task automatic waitSel(input int s, input logic lvl, output int n);
		logic x;
		for (int k = 0; k < 300; k++) begin
			@(posedge clock);
			#1;
			x = (s == 0) ? baseBlock : (s == 1) ? contactorDriveLow : (s == 2) ? gainLoad :
				(s == 3) ? windingStatus : (s == 4) ? servoOn : speedMatch;
			n = k + 1;
			if (x === lvl) return;
		end
		chk("timeout", 16'h0000, 16'h0001);
		final_report();
	endtask

	task automatic noChange(input logic req, input logic st);
		send(req, 2'h1);
		repeat (20) @(posedge clock);
		#1;
		chk("baseBlock", 16'h0000, {15'h0, baseBlock});
		chk("windingStatus", {15'h0, st}, {15'h0, windingStatus});
	endtask

	task automatic change(input logic req, input logic [1:0] gs, input logic [15:0] ef);
		send(req, gs);
		waitSel(0, 1'b1, c);
		chk("servoOn", 16'h0000, {15'h0, servoOn});
		chk("speedMatch", 16'h0000, {15'h0, speedMatch});
		waitSel(1, req, c);
		chk("switchDelay", 16'(D), 16'(c));
		waitSel(2, 1'b1, c);
		chk("gainBank", {14'h0, gs}, {14'h0, gainBank});
		chk("controlLow", {15'h0, req}, {15'h0, controlLow});
		chk("heldStatus", {15'h0, ~req}, {15'h0, windingStatus});
		waitSel(3, req, c);
		chk("fbBeforeOn", {15'h0, req}, {15'h0, contactorFbLowPin});
		chk("blockAtStatus", 16'h0000, {15'h0, baseBlock});
		waitSel(4, 1'b1, c);
		chk("fluxLevel", ef, fluxLevel);
		chk("baseRatio", req ? 16'h01f4 : 16'h0064, baseSpeedRatio);
		waitSel(5, 1'b1, c);
		rd(OFS_STATUS, rv);
		chk("status", {12'h0, 3'b011, req}, rv & 16'h000f);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rv = $urandom(32'h844b);
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		for (i = 0; i < 5; i++) begin
			rd(3'(i), rv);
			chk("resetReg", (i == 0) ? APP_CFG_RST : 16'h0064, rv);
		end
		rd(3'h7, rv);
		chk("unmapped", 16'h0000, rv);
		noChange(1'b1, 1'b0);
		// withdraw the ignored request so enabling a method does not start a changeover
		send(1'b0, 2'h0);
		hiF = 16'(30 + $urandom % 71);
		loF = 16'(30 + $urandom % 71);
		wr(OFS_HI_FLUX, hiF);
		wr(OFS_LO_FLUX, loF);
		wr(OFS_HI_FLUX, 16'h001d);
		wr(OFS_LO_FLUX, 16'h0065);
		rd(OFS_HI_FLUX, rv);
		chk("hiFlux", hiF, rv);
		rd(OFS_LO_FLUX, rv);
		chk("loFlux", loF, rv);
		chk("fluxNow", hiF, fluxLevel);
		wr(OFS_HI_BASE, 16'h01f5);
		wr(OFS_LO_BASE, 16'h0063);
		wr(OFS_LO_BASE, 16'h01f4);
		rd(OFS_HI_BASE, rv);
		chk("hiBase", 16'h0064, rv);
		rd(OFS_LO_BASE, rv);
		chk("loBase", 16'h01f4, rv);
		wr(OFS_APP_CFG, 16'h0026);
		wr(OFS_APP_CFG, 16'h0036);
		rd(OFS_APP_CFG, rv);
		chk("cfgRefused", 16'h0000, rv);
		for (i = 0; i < 6; i++) begin
			wr(OFS_APP_CFG, 16'((i % 3) * 16 + i));
			chk("beforeRestart", 16'((i == 0) ? 0 : (i + 2) % 3), {14'h0, windingMethod});
			wr(OFS_CTRL, 16'h0001);
			repeat (2) @(posedge clock);
			#1;
			chk("motorType", 16'(i), {13'h0, motorType});
			chk("method", 16'(i % 3), {14'h0, windingMethod});
		end
		noChange(1'b0, 1'b0);
		for (i = 0; i < 5; i++) begin
			fbDelay <= 8'(2 + $urandom % 60);
			g = 2'($urandom);
			change(~i[0], g, i[0] ? hiF : loF);
		end
		noChange(1'b1, 1'b1);
		final_report();
	end
endmodule
